// ### hdl/gpib_pkg.sv
// Purpose: shared constants for the instrument-side bus port
// Assumes: 7-bit command codes, bus lines in negative logic at the pins
// Notes: state codes are Gray along the usual acceptor path; source SRC_VALID back to SRC_IDLE flips both bits
package gpib_pkg;
   // address field
   localparam int ADDR_W = 5;
   localparam int CMD_W = 7;
   // addressed command groups, upper two bits of a command byte
   localparam logic [1:0] LISTEN_GRP = 2'h1;
   localparam logic [1:0] TALK_GRP = 2'h2;
   // universal and addressed interface commands
   localparam logic [6:0] CMD_UNLISTEN = 7'h3F;
   localparam logic [6:0] CMD_UNTALK = 7'h5F;
   localparam logic [6:0] CMD_DEV_CLEAR = 7'h14;
   localparam logic [6:0] CMD_SEL_CLEAR = 7'h04;
   localparam logic [6:0] CMD_TRIGGER = 7'h08;
   localparam logic [6:0] CMD_TO_LOCAL = 7'h01;
   localparam logic [6:0] CMD_LOCKOUT = 7'h11;
   localparam logic [6:0] CMD_POLL_ON = 7'h18;
   localparam logic [6:0] CMD_POLL_OFF = 7'h19;
   // response terminator
   localparam logic [7:0] LINE_FEED = 8'h0A;
   // status byte bit that reports a pending service request
   localparam int RQS_BIT = 6;
   // receive buffer shape
   localparam int RX_WIDTH = 9;
   localparam int RX_DEPTH = 16;
   // acceptor handshake states
   typedef enum logic [1:0] {
      ACC_IDLE = 2'h0,
      ACC_READY = 2'h1,
      ACC_DONE = 2'h3
   } acc_state_e;
   // source handshake states
   typedef enum logic [1:0] {
      SRC_IDLE = 2'h0,
      SRC_SETUP = 2'h1,
      SRC_VALID = 2'h3
   } src_state_e;
endpackage

// ### hdl/byte_fifo.sv
// Purpose: synchronous FIFO for received bus bytes
// Assumes: one clock, synchronous active-high reset and flush
// Notes: DEPTH must be a power of two
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 16
) (
   // system
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_flush,
   // fill side
   input wire logic [WIDTH-1:0] i_data,
   input wire logic i_valid,
   output logic o_ready,
   // drain side
   output logic [WIDTH-1:0] o_data,
   output logic o_valid,
   input wire logic i_ready
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr;
   logic [AW:0] rd_ptr;
   logic [AW:0] used;
   logic push;
   logic pop;

   // occupancy from the pointer difference, extra bit tells full from empty
   assign used = wr_ptr - rd_ptr;
   assign o_ready = (used != FULL_COUNT);
   assign o_valid = (used != '0);
   assign push = i_valid && o_ready;
   assign pop = o_valid && i_ready;
   assign o_data = mem[rd_ptr[AW-1:0]];

   // storage, no reset needed for the data words
   always_ff @(posedge i_clk) begin
      if (push) begin
         mem[wr_ptr[AW-1:0]] <= i_data;
      end
   end

   // pointers; flush drops everything held
   always_ff @(posedge i_clk) begin
      if (i_rst || i_flush) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// ### hdl/gpib_port.sv
// Purpose: instrument-side bus port: handshakes, addressing, interface messages
// Assumes: bus pins synchronous to I_CORE_CLK, negative logic on all bus lines
// Notes: one-way handshake lines are open drain, only the enable matters
`timescale 1ns/1ps
`default_nettype none
module gpib_port #(
   parameter int FIFO_DEPTH = gpib_pkg::RX_DEPTH
) (
   // system
   input wire logic I_CORE_CLK,
   input wire logic I_RST,
   // data lines
   input wire logic [7:0] I_DIO_N,
   output logic [7:0] O_DIO_N,
   output logic O_DIO_OE,
   // handshake lines
   input wire logic I_DAV_N,
   output logic O_DAV_N,
   output logic O_DAV_OE,
   input wire logic I_NRFD_N,
   output logic O_NRFD_N,
   output logic O_NRFD_OE,
   input wire logic I_NDAC_N,
   output logic O_NDAC_N,
   output logic O_NDAC_OE,
   // management lines
   input wire logic I_ATN_N,
   input wire logic I_IFC_N,
   input wire logic I_REN_N,
   input wire logic I_EOI_N,
   output logic O_EOI_N,
   output logic O_EOI_OE,
   output logic O_SRQ_N,
   output logic O_SRQ_OE,
   // configuration
   input wire logic [gpib_pkg::ADDR_W-1:0] I_BUS_ADDR,
   // received text stream
   output logic [7:0] O_RX_DATA,
   output logic O_RX_END,
   output logic O_RX_VALID,
   input wire logic I_RX_READY,
   // response stream
   input wire logic [7:0] I_TX_DATA,
   input wire logic I_TX_LAST,
   input wire logic I_TX_VALID,
   output logic O_TX_READY,
   // status and service
   input wire logic [7:0] I_STATUS_BYTE,
   input wire logic I_SERVICE_REQ,
   input wire logic I_PANEL_LOCAL,
   // events and state
   output logic O_DEV_CLEAR,
   output logic O_TRIGGER,
   output logic O_REMOTE,
   output logic O_LOCKOUT,
   output logic O_LISTEN,
   output logic O_TALK,
   output logic O_SERIAL_POLL
);
   gpib_pkg::acc_state_e acc;
   gpib_pkg::src_state_e src;
   logic atn, ifc, ren, dav, others_busy, ndac_low, eoi_in;
   logic [7:0] bus_byte;
   logic [6:0] cmd;
   logic listen, talk, poll_mode, remote, lockout;
   logic take, ready_ok, latch, cmd_take, rx_push, rx_ready;
   logic is_mla, is_mta, other_talk;
   logic dev_clear, trigger;
   logic [7:0] dio_out;
   logic eoi_out, lf_pending, stb_sent, stb_out, rqs, svc_q;
   logic tx_active, tx_take;

   // matches a command byte against this device's address in a group
   function automatic logic addr_hit(input logic [6:0] c, input logic [1:0] grp,
                                     input logic [gpib_pkg::ADDR_W-1:0] adr);
      addr_hit = (c == {grp, adr});
   endfunction

   // bus lines are negative logic; turn them into active-high terms
   assign atn = ~I_ATN_N;
   assign ifc = ~I_IFC_N;
   assign ren = ~I_REN_N;
   assign dav = ~I_DAV_N;
   assign others_busy = ~I_NRFD_N;
   assign ndac_low = ~I_NDAC_N;
   assign eoi_in = ~I_EOI_N;
   assign bus_byte = ~I_DIO_N;
   assign cmd = bus_byte[6:0];

   // every device takes part while attention is up; text only if listening
   assign take = atn || listen;
   // commands are never held off; text waits for buffer room
   assign ready_ok = atn || rx_ready;
   assign latch = (acc == gpib_pkg::ACC_READY) && take && dav && ready_ok;
   assign cmd_take = latch && atn;
   assign rx_push = latch && !atn && listen;

   // address recognition
   assign is_mla = addr_hit(cmd, gpib_pkg::LISTEN_GRP, I_BUS_ADDR) &&
                   (cmd != gpib_pkg::CMD_UNLISTEN);
   assign is_mta = addr_hit(cmd, gpib_pkg::TALK_GRP, I_BUS_ADDR) &&
                   (cmd != gpib_pkg::CMD_UNTALK);
   assign other_talk = (cmd[6:5] == gpib_pkg::TALK_GRP) && !is_mta;

   // acceptor handshake, sequenced here with no firmware in the loop
   always_ff @(posedge I_CORE_CLK) begin
      if (I_RST || ifc) begin
         acc <= gpib_pkg::ACC_IDLE;
      end else begin
         unique case (acc)
            gpib_pkg::ACC_IDLE: begin
               if (take) begin
                  acc <= gpib_pkg::ACC_READY;
               end
            end
            gpib_pkg::ACC_READY: begin
               if (!take) begin
                  acc <= gpib_pkg::ACC_IDLE;
               end else if (latch) begin
                  acc <= gpib_pkg::ACC_DONE;
               end
            end
            gpib_pkg::ACC_DONE: begin
               // finish the byte even if attention changed meanwhile
               if (!dav) begin
                  acc <= take ? gpib_pkg::ACC_READY : gpib_pkg::ACC_IDLE;
               end
            end
            default: begin
               acc <= gpib_pkg::ACC_IDLE;
            end
         endcase
      end
   end

   // acceptor pin drive: open drain, only the enables carry information
   assign O_NRFD_OE = ((acc == gpib_pkg::ACC_READY) && !ready_ok) ||
                      (acc == gpib_pkg::ACC_DONE);
   assign O_NDAC_OE = (acc == gpib_pkg::ACC_READY);
   assign O_NRFD_N = 1'b0;
   assign O_NDAC_N = 1'b0;

   // listener addressing; own talk address unaddresses the listener
   always_ff @(posedge I_CORE_CLK) begin
      if (I_RST || ifc) begin
         listen <= 1'b0;
      end else if (cmd_take) begin
         if (cmd == gpib_pkg::CMD_UNLISTEN) begin
            listen <= 1'b0;
         end else if (is_mla) begin
            listen <= 1'b1;
         end else if (is_mta) begin
            listen <= 1'b0;
         end
      end
   end

   // talker addressing; another talker's address or own listen drops it
   always_ff @(posedge I_CORE_CLK) begin
      if (I_RST || ifc) begin
         talk <= 1'b0;
      end else if (cmd_take) begin
         if (cmd == gpib_pkg::CMD_UNTALK || other_talk || is_mla) begin
            talk <= 1'b0;
         end else if (is_mta) begin
            talk <= 1'b1;
         end
      end
   end

   // serial poll mode
   always_ff @(posedge I_CORE_CLK) begin
      if (I_RST || ifc) begin
         poll_mode <= 1'b0;
      end else if (cmd_take && cmd == gpib_pkg::CMD_POLL_ON) begin
         poll_mode <= 1'b1;
      end else if (cmd_take && cmd == gpib_pkg::CMD_POLL_OFF) begin
         poll_mode <= 1'b0;
      end
   end

   // one-cycle events for the instrument; selected clear needs listener state
   always_ff @(posedge I_CORE_CLK) begin
      if (I_RST) begin
         dev_clear <= 1'b0;
         trigger <= 1'b0;
      end else begin
         dev_clear <= cmd_take && (cmd == gpib_pkg::CMD_DEV_CLEAR ||
                      (cmd == gpib_pkg::CMD_SEL_CLEAR && listen));
         trigger <= cmd_take && cmd == gpib_pkg::CMD_TRIGGER && listen;
      end
   end

   // remote/local: remote enable off forces local and lifts lockout
   always_ff @(posedge I_CORE_CLK) begin
      if (I_RST || !ren) begin
         remote <= 1'b0;
         lockout <= 1'b0;
      end else begin
         if (cmd_take && cmd == gpib_pkg::CMD_LOCKOUT) begin
            lockout <= 1'b1;
         end
         if (cmd_take && is_mla) begin
            remote <= 1'b1;
         end else if (cmd_take && cmd == gpib_pkg::CMD_TO_LOCAL && listen) begin
            remote <= 1'b0;
         end else if (I_PANEL_LOCAL && !lockout) begin
            remote <= 1'b0;
         end
      end
   end

   // receive buffer; the end flag travels with its byte, clear empties it
   byte_fifo #(
      .WIDTH(gpib_pkg::RX_WIDTH),
      .DEPTH(FIFO_DEPTH)
   ) rx_buf (
      .i_clk(I_CORE_CLK),
      .i_rst(I_RST),
      .i_flush(dev_clear),
      .i_data({eoi_in, bus_byte}),
      .i_valid(rx_push),
      .o_ready(rx_ready),
      .o_data({O_RX_END, O_RX_DATA}),
      .o_valid(O_RX_VALID),
      .i_ready(I_RX_READY)
   );

   // source side: talks only while attention is down
   assign tx_active = talk && !atn;
   assign O_TX_READY = tx_active && !poll_mode && !lf_pending &&
                       (src == gpib_pkg::SRC_IDLE);
   assign tx_take = O_TX_READY && I_TX_VALID;

   // source handshake; data loads one cycle ahead of data valid
   always_ff @(posedge I_CORE_CLK) begin
      if (I_RST || ifc || dev_clear) begin
         src <= gpib_pkg::SRC_IDLE;
         dio_out <= 8'h00;
         eoi_out <= 1'b0;
         stb_out <= 1'b0;
      end else begin
         unique case (src)
            gpib_pkg::SRC_IDLE: begin
               if (tx_active && poll_mode && !stb_sent) begin
                  dio_out <= {I_STATUS_BYTE[7], rqs, I_STATUS_BYTE[5:0]};
                  eoi_out <= 1'b0;
                  stb_out <= 1'b1;
                  src <= gpib_pkg::SRC_SETUP;
               end else if (tx_active && !poll_mode && lf_pending) begin
                  dio_out <= gpib_pkg::LINE_FEED;
                  eoi_out <= 1'b1;
                  stb_out <= 1'b0;
                  src <= gpib_pkg::SRC_SETUP;
               end else if (tx_take) begin
                  dio_out <= I_TX_DATA;
                  eoi_out <= 1'b0;
                  stb_out <= 1'b0;
                  src <= gpib_pkg::SRC_SETUP;
               end
            end
            gpib_pkg::SRC_SETUP: begin
               // a byte cut off by attention is dropped, not repeated
               if (atn) begin
                  src <= gpib_pkg::SRC_IDLE;
               end else if (!others_busy && ndac_low) begin
                  src <= gpib_pkg::SRC_VALID;
               end
            end
            gpib_pkg::SRC_VALID: begin
               if (atn || !ndac_low) begin
                  src <= gpib_pkg::SRC_IDLE;
               end
            end
            default: begin
               src <= gpib_pkg::SRC_IDLE;
            end
         endcase
      end
   end

   // terminator pending after the last response byte
   always_ff @(posedge I_CORE_CLK) begin
      if (I_RST || ifc || dev_clear) begin
         lf_pending <= 1'b0;
      end else if (tx_take) begin
         lf_pending <= I_TX_LAST;
      end else if (src == gpib_pkg::SRC_IDLE && tx_active && !poll_mode) begin
         lf_pending <= 1'b0;
      end
   end

   // status byte goes out once after each command byte taken while polled
   always_ff @(posedge I_CORE_CLK) begin
      if (I_RST || ifc || cmd_take) begin
         stb_sent <= 1'b0;
      end else if (src == gpib_pkg::SRC_IDLE && tx_active && poll_mode) begin
         stb_sent <= 1'b1;
      end
   end

   // service request: set on a new request, cleared once polled; set wins
   always_ff @(posedge I_CORE_CLK) begin
      if (I_RST) begin
         svc_q <= 1'b0;
         rqs <= 1'b0;
      end else begin
         svc_q <= I_SERVICE_REQ;
         if (I_SERVICE_REQ && !svc_q) begin
            rqs <= 1'b1;
         end else if (src == gpib_pkg::SRC_VALID && stb_out && !ndac_low) begin
            rqs <= 1'b0;
         end
      end
   end

   // pin drive; data lines released whenever no byte is offered
   assign O_DIO_N = ~dio_out;
   assign O_DIO_OE = (src != gpib_pkg::SRC_IDLE) && !atn;
   assign O_DAV_N = 1'b0;
   assign O_DAV_OE = (src == gpib_pkg::SRC_VALID) && !atn;
   assign O_EOI_N = 1'b0;
   assign O_EOI_OE = O_DIO_OE && eoi_out;
   assign O_SRQ_N = 1'b0;
   assign O_SRQ_OE = rqs;

   // state seen by the instrument
   assign O_DEV_CLEAR = dev_clear;
   assign O_TRIGGER = trigger;
   assign O_REMOTE = remote;
   assign O_LOCKOUT = lockout;
   assign O_LISTEN = listen;
   assign O_TALK = talk;
   assign O_SERIAL_POLL = poll_mode;

   // checks
   default clocking @(posedge I_CORE_CLK); endclocking
   default disable iff (I_RST);

   atn_accept_a: assert property (atn && !ifc && acc == gpib_pkg::ACC_READY && dav |=>
      acc == gpib_pkg::ACC_DONE) else $error("attention byte not accepted");
   text_gate_a: assert property (rx_push |-> listen && I_ATN_N)
      else $error("text byte taken while unaddressed");
   not_ready_a: assert property (acc == gpib_pkg::ACC_DONE |-> O_NRFD_OE)
      else $error("ready released before byte finished");
   accept_hold_a: assert property (latch && !ifc |-> O_NDAC_OE ##1 !O_NDAC_OE)
      else $error("accept not signalled after latch");
   dav_setup_a: assert property ($rose(O_DAV_OE) |-> $stable(O_DIO_N) &&
      $past(O_DIO_OE)) else $error("data valid without settled data");
   clear_event_a: assert property (cmd_take && !ifc && cmd == gpib_pkg::CMD_DEV_CLEAR
      |=> O_DEV_CLEAR ##2 !O_RX_VALID) else $error("device clear not carried out");
   sel_clear_a: assert property (cmd_take && cmd == gpib_pkg::CMD_SEL_CLEAR && !listen
      |=> !O_DEV_CLEAR) else $error("selected clear acted while unaddressed");
   trigger_event_a: assert property (O_TRIGGER |-> $past(listen) && $past(cmd_take))
      else $error("trigger without addressed trigger command");
   end_lf_a: assert property (O_EOI_OE |-> ~O_DIO_N == gpib_pkg::LINE_FEED)
      else $error("end asserted on a byte other than line feed");
   go_local_a: assert property (cmd_take && !ifc && ren && listen &&
      cmd == gpib_pkg::CMD_TO_LOCAL |=> !O_REMOTE) else $error("go to local ignored");
   ifc_idle_a: assert property (ifc |=> !O_LISTEN && !O_TALK && !O_SERIAL_POLL &&
      acc == gpib_pkg::ACC_IDLE) else $error("interface clear left port addressed");
   listen_addr_a: assert property (cmd_take && !ifc && is_mla |=> O_LISTEN && !O_TALK)
      else $error("own listen address not recognised");
   untalk_a: assert property (cmd_take && !ifc && cmd == gpib_pkg::CMD_UNTALK |=>
      !O_TALK) else $error("untalk ignored");
   full_hold_a: assert property (listen && !atn && !rx_ready &&
      acc != gpib_pkg::ACC_IDLE |-> O_NRFD_OE) else $error("not ready released while full");
   ren_off_a: assert property (!ren |=> !O_REMOTE && !O_LOCKOUT)
      else $error("remote state kept without remote enable");
endmodule
`default_nettype wire

// ### verification/bus_ctrl_model.sv
// Purpose: behavioural bus controller facing the instrument port
// Assumes: every bus line has a pull-up, so a released line reads high
// Notes: slow delays data valid when sourcing and the accept when reading; errs counts waits that ran out
`timescale 1ns/1ps
`default_nettype none
module bus_ctrl_model (
   // clock
   input wire logic i_clk,
   // device drivers
   input wire logic [7:0] i_dio_n,
   input wire logic i_dio_oe,
   input wire logic i_dav_oe,
   input wire logic i_nrfd_oe,
   input wire logic i_ndac_oe,
   input wire logic i_eoi_oe,
   // resolved wire levels
   output logic [7:0] o_dio_n,
   output logic o_dav_n,
   output logic o_nrfd_n,
   output logic o_ndac_n,
   output logic o_eoi_n,
   output logic o_atn_n
);
   logic [7:0] m_dio = 8'h00;
   logic m_dav = 1'b0;
   logic m_nrfd = 1'b0;
   logic m_ndac = 1'b0;
   logic m_eoi = 1'b0;
   logic m_atn = 1'b0;
   int slow = 0;
   int errs = 0;
   // wired-or of both parties; pull-ups win when nobody pulls
   assign o_dio_n = ~m_dio & (i_dio_oe ? i_dio_n : 8'hFF);
   assign o_dav_n = ~(m_dav | i_dav_oe);
   assign o_nrfd_n = ~(m_nrfd | i_nrfd_oe);
   assign o_ndac_n = ~(m_ndac | i_ndac_oe);
   assign o_eoi_n = ~(m_eoi | i_eoi_oe);
   assign o_atn_n = ~m_atn;
   // handshake line picked by number
   function automatic logic lvl(input int sel);
      case (sel)
         0: return o_nrfd_n;
         1: return o_ndac_n;
         default: return o_dav_n;
      endcase
   endfunction
   // sampled at falling edges, where the port's outputs have settled
   task automatic wait_for(input int sel, input logic v);
      int n;
      n = 0;
      @(negedge i_clk);
      while (lvl(sel) !== v && n < 400) begin
         @(negedge i_clk);
         n++;
      end
      if (n >= 400) errs++;
   endtask
   // source one byte; data and end settle a full cycle before valid
   task automatic send_byte(input logic atn, input logic [7:0] b, input logic eoi);
      @(posedge i_clk);
      m_atn <= atn;
      m_dio <= b;
      m_eoi <= eoi;
      wait_for(0, 1'b1);
      repeat (slow) @(posedge i_clk);
      @(posedge i_clk);
      m_dav <= 1'b1;
      wait_for(1, 1'b1);
      @(posedge i_clk);
      m_dav <= 1'b0;
      m_dio <= 8'h00;
      m_eoi <= 1'b0;
   endtask
   // accept one byte from the talking port
   task automatic read_byte(output logic [7:0] b, output logic e);
      @(posedge i_clk);
      m_atn <= 1'b0;
      m_ndac <= 1'b1;
      wait_for(2, 1'b0);
      b = ~o_dio_n;
      e = ~o_eoi_n;
      repeat (slow) @(posedge i_clk);
      @(posedge i_clk);
      m_ndac <= 1'b0;
      m_nrfd <= 1'b1;
      wait_for(2, 1'b1);
      @(posedge i_clk);
      m_nrfd <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ### verification/test_gpib_port.sv
// Purpose: self-checking bench for the instrument-side bus port
// Assumes: own address 5, remote enable asserted except in the local case
// Notes: command rows first, then buffer, clear, talker, poll, interface clear and local cases
`timescale 1ns/1ps
`default_nettype none
module test_gpib_port;
   typedef struct packed {
      logic atn;
      logic [7:0] b;
      logic [4:0] st;
      logic clr;
      logic trg;
   } row_s;
   // st holds listen, talk, remote, lockout, poll after the byte
   localparam row_s ROWS [17] = '{
      '{1'b1, 8'h25, 5'h14, 1'b0, 1'b0}, '{1'b1, 8'h04, 5'h14, 1'b1, 1'b0},
      '{1'b1, 8'h08, 5'h14, 1'b0, 1'b1}, '{1'b1, 8'h11, 5'h16, 1'b0, 1'b0},
      '{1'b1, 8'h01, 5'h12, 1'b0, 1'b0}, '{1'b1, 8'h3F, 5'h02, 1'b0, 1'b0},
      '{1'b1, 8'h04, 5'h02, 1'b0, 1'b0}, '{1'b1, 8'h08, 5'h02, 1'b0, 1'b0},
      '{1'b1, 8'h45, 5'h0A, 1'b0, 1'b0}, '{1'b1, 8'h25, 5'h16, 1'b0, 1'b0},
      '{1'b1, 8'h45, 5'h0E, 1'b0, 1'b0}, '{1'b1, 8'h5F, 5'h06, 1'b0, 1'b0},
      '{1'b1, 8'h18, 5'h07, 1'b0, 1'b0}, '{1'b1, 8'h19, 5'h06, 1'b0, 1'b0},
      '{1'b1, 8'h14, 5'h06, 1'b1, 1'b0}, '{1'b1, 8'h45, 5'h0E, 1'b0, 1'b0},
      '{1'b1, 8'h46, 5'h06, 1'b0, 1'b0}};
   logic I_CORE_CLK = 1'b0;
   logic I_RST = 1'b1;
   logic I_IFC_N = 1'b1;
   logic I_REN_N = 1'b0;
   logic I_RX_READY = 1'b0;
   logic [7:0] I_TX_DATA = 8'h00;
   logic I_TX_LAST = 1'b0;
   logic I_TX_VALID = 1'b0;
   logic I_SERVICE_REQ = 1'b0;
   logic I_PANEL_LOCAL = 1'b0;
   logic [7:0] dio_n, o_dio_n, rd [3], rb;
   logic dav_n, nrfd_n, ndac_n, eoi_n, atn_n, re [3], rx_end, rx_valid;
   logic dio_oe, dav_oe, nrfd_oe, ndac_oe, eoi_oe, srq_oe, tx_ready;
   logic clr_p, trg_p, remote, lockout, listen, talk, poll, e;
   logic [7:0] rx_data;
   int bad_count = 0;
   int n_checks = 0;
   int clr_cnt = 0;
   int trg_cnt = 0;
   int c0, t0;
   always #12.5 I_CORE_CLK = ~I_CORE_CLK;
   gpib_port dut_u (.I_CORE_CLK(I_CORE_CLK), .I_RST(I_RST), .I_DIO_N(dio_n),
      .O_DIO_N(o_dio_n), .O_DIO_OE(dio_oe), .I_DAV_N(dav_n), .O_DAV_N(),
      .O_DAV_OE(dav_oe), .I_NRFD_N(nrfd_n), .O_NRFD_N(), .O_NRFD_OE(nrfd_oe),
      .I_NDAC_N(ndac_n), .O_NDAC_N(), .O_NDAC_OE(ndac_oe), .I_ATN_N(atn_n),
      .I_IFC_N(I_IFC_N), .I_REN_N(I_REN_N), .I_EOI_N(eoi_n), .O_EOI_N(),
      .O_EOI_OE(eoi_oe), .O_SRQ_N(), .O_SRQ_OE(srq_oe), .I_BUS_ADDR(5'h05),
      .O_RX_DATA(rx_data), .O_RX_END(rx_end), .O_RX_VALID(rx_valid),
      .I_RX_READY(I_RX_READY), .I_TX_DATA(I_TX_DATA), .I_TX_LAST(I_TX_LAST),
      .I_TX_VALID(I_TX_VALID), .O_TX_READY(tx_ready), .I_STATUS_BYTE(8'h05),
      .I_SERVICE_REQ(I_SERVICE_REQ), .I_PANEL_LOCAL(I_PANEL_LOCAL), .O_DEV_CLEAR(clr_p),
      .O_TRIGGER(trg_p), .O_REMOTE(remote), .O_LOCKOUT(lockout), .O_LISTEN(listen),
      .O_TALK(talk), .O_SERIAL_POLL(poll));
   bus_ctrl_model ctl_u (.i_clk(I_CORE_CLK), .i_dio_n(o_dio_n), .i_dio_oe(dio_oe),
      .i_dav_oe(dav_oe), .i_nrfd_oe(nrfd_oe), .i_ndac_oe(ndac_oe), .i_eoi_oe(eoi_oe),
      .o_dio_n(dio_n), .o_dav_n(dav_n), .o_nrfd_n(nrfd_n), .o_ndac_n(ndac_n),
      .o_eoi_n(eoi_n), .o_atn_n(atn_n));
   // pulses are one cycle wide, so count them rather than sample them
   always @(posedge I_CORE_CLK) begin
      if (clr_p === 1'b1) clr_cnt <= clr_cnt + 1;
      if (trg_p === 1'b1) trg_cnt <= trg_cnt + 1;
   end
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic tally_and_finish;
      if (bad_count == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // offer one response byte, held until the port takes it
   task automatic tx_put(input logic [7:0] d, input logic last);
      int n;
      n = 0;
      @(posedge I_CORE_CLK);
      I_TX_DATA <= d;
      I_TX_LAST <= last;
      I_TX_VALID <= 1'b1;
      @(negedge I_CORE_CLK);
      while (tx_ready !== 1'b1 && n < 400) begin
         @(negedge I_CORE_CLK);
         n++;
      end
      if (n >= 400) bad_count++;
      @(posedge I_CORE_CLK);
      I_TX_VALID <= 1'b0;
   endtask
   // a hang ends the run through the same closing task
   initial begin
      repeat (20000) @(posedge I_CORE_CLK);
      bad_count++;
      tally_and_finish;
   end
   initial begin
      repeat (6) @(posedge I_CORE_CLK);
      I_RST <= 1'b0;
      @(negedge I_CORE_CLK);
      check("idle", 8'h00, {2'h0, listen, talk, remote, rx_valid, dio_oe, srq_oe});
      foreach (ROWS[i]) begin
         c0 = clr_cnt;
         t0 = trg_cnt;
         ctl_u.send_byte(ROWS[i].atn, ROWS[i].b, 1'b0);
         repeat (2) @(negedge I_CORE_CLK);
         check("state", {3'h0, ROWS[i].st}, {3'h0, listen, talk, remote, lockout, poll});
         check("clears", 8'(ROWS[i].clr), 8'(clr_cnt - c0));
         check("triggers", 8'(ROWS[i].trg), 8'(trg_cnt - t0));
      end
      // text while unaddressed is not taken
      ctl_u.send_byte(1'b0, 8'h41, 1'b0);
      @(negedge I_CORE_CLK);
      check("unaddressed text", 8'h00, 8'(rx_valid));
      // fill the buffer with a slow source, then drain it with stalls
      ctl_u.slow = 2;
      ctl_u.send_byte(1'b1, 8'h25, 1'b0);
      for (int i = 0; i < 16; i++) ctl_u.send_byte(1'b0, 8'h30 + 8'(i), i == 15);
      repeat (2) @(negedge I_CORE_CLK);
      check("full holds not ready", 8'h01, 8'(nrfd_oe));
      for (int i = 0; i < 16; i++) begin
         @(negedge I_CORE_CLK);
         check("rx byte", 8'h30 + 8'(i), rx_data);
         check("rx end", 8'(i == 15), 8'(rx_end));
         @(posedge I_CORE_CLK);
         I_RX_READY <= 1'b1;
         @(posedge I_CORE_CLK);
         I_RX_READY <= 1'b0;
      end
      repeat (2) @(negedge I_CORE_CLK);
      check("drained", 8'h00, {6'h0, rx_valid, nrfd_oe});
      // a clear empties what was received
      ctl_u.send_byte(1'b0, 8'h55, 1'b0);
      ctl_u.send_byte(1'b1, 8'h14, 1'b0);
      repeat (3) @(negedge I_CORE_CLK);
      check("flushed", 8'h00, 8'(rx_valid));
      // response of two bytes, stalled reader, port appends the end byte
      ctl_u.send_byte(1'b1, 8'h3F, 1'b0);
      ctl_u.send_byte(1'b1, 8'h45, 1'b0);
      ctl_u.slow = 3;
      fork
         begin
            tx_put(8'h58, 1'b0);
            tx_put(8'h59, 1'b1);
         end
         for (int k = 0; k < 3; k++) ctl_u.read_byte(rd[k], re[k]);
      join
      for (int k = 0; k < 3; k++) begin
         check("tx byte", (k == 2) ? gpib_pkg::LINE_FEED : 8'h58 + 8'(k), rd[k]);
         check("tx end", 8'(k == 2), 8'(re[k]));
      end
      // service request, then a poll that returns the status byte
      ctl_u.slow = 0;
      @(posedge I_CORE_CLK);
      I_SERVICE_REQ <= 1'b1;
      repeat (3) @(negedge I_CORE_CLK);
      check("srq raised", 8'h01, 8'(srq_oe));
      ctl_u.send_byte(1'b1, 8'h18, 1'b0);
      ctl_u.send_byte(1'b1, 8'h45, 1'b0);
      ctl_u.read_byte(rb, e);
      check("status byte", 8'h05 | (8'h01 << gpib_pkg::RQS_BIT), rb);
      check("status end", 8'h00, 8'(e));
      repeat (2) @(negedge I_CORE_CLK);
      check("srq cleared", 8'h00, 8'(srq_oe));
      ctl_u.send_byte(1'b1, 8'h19, 1'b0);
      // interface clear drops every address
      ctl_u.send_byte(1'b1, 8'h25, 1'b0);
      @(posedge I_CORE_CLK);
      I_IFC_N <= 1'b0;
      repeat (3) @(posedge I_CORE_CLK);
      I_IFC_N <= 1'b1;
      @(negedge I_CORE_CLK);
      check("after ifc", 8'h00, {5'h0, listen, talk, poll});
      // panel local blocked by lockout; remote enable off clears both
      @(posedge I_CORE_CLK);
      I_PANEL_LOCAL <= 1'b1;
      repeat (2) @(negedge I_CORE_CLK);
      check("locked out", 8'h03, {6'h0, remote, lockout});
      @(posedge I_CORE_CLK);
      I_REN_N <= 1'b1;
      repeat (2) @(negedge I_CORE_CLK);
      check("ren off", 8'h00, {6'h0, remote, lockout});
      @(posedge I_CORE_CLK);
      I_REN_N <= 1'b0;
      I_PANEL_LOCAL <= 1'b0;
      ctl_u.send_byte(1'b1, 8'h25, 1'b0);
      @(negedge I_CORE_CLK);
      check("remote by address", 8'h02, {6'h0, remote, lockout});
      @(posedge I_CORE_CLK);
      I_PANEL_LOCAL <= 1'b1;
      repeat (2) @(negedge I_CORE_CLK);
      check("panel local", 8'h00, {6'h0, remote, lockout});
      check("model waits", 8'h00, 8'(ctl_u.errs));
      tally_and_finish;
   end
endmodule
`default_nettype wire
